/* File: hdl/sei_slave.sv */
// Two-wire bus slave in front of a byte-wide nonvolatile array
`timescale 1ns/1ps
module sei_slave #(
	parameter int unsigned P_MEM_BYTES = sei_pkg::MEM_BYTES,
	parameter int unsigned P_PAGE_BYTES = sei_pkg::PAGE_BYTES,
	parameter int unsigned P_PROG_CYCLES = sei_pkg::PROG_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_supervisor_reset,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_busy
);
	import sei_pkg::*;

	// ---------------------------------------------------------------
	// Derived sizes and elaboration checks
	// ---------------------------------------------------------------
	localparam int AW = $clog2(P_MEM_BYTES);
	localparam int PW = $clog2(P_PAGE_BYTES);
	localparam int CW = $clog2(P_PROG_CYCLES + 1);
	localparam logic [CW-1:0] PROG_LAST = CW'(P_PROG_CYCLES - 1);
	localparam logic [CW-1:0] PAGE_END = CW'(P_PAGE_BYTES);

	// Refused while building, so a size the logic cannot serve never elaborates
	if (P_MEM_BYTES != (1 << AW) || AW <= 8 || AW > 16) begin : g_bad_mem
		$error("memory size must be a power of two, 512 to 65536");
	end
	if (P_PAGE_BYTES != (1 << PW) || PW < 1 || PW >= AW) begin : g_bad_page
		$error("page size must be a power of two below memory size");
	end
	// The drain walks the page one byte a cycle inside the program cycle
	if (P_PROG_CYCLES <= P_PAGE_BYTES) begin : g_bad_prog
		$error("programming cycle too short to drain the page");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic rst_m;
		logic rst_s;
		sei_phase_type phase;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rw;
		logic master_ack;
		logic [1:0] byte_idx;
		logic [AW-1:0] addr;
		logic pending;
		logic [P_PAGE_BYTES-1:0] fill;
		logic [AW-PW-1:0] page_base;
		logic sda_oe;
		logic sda_out;
		logic busy;
		logic [CW-1:0] prog_cnt;
	} sei_ctrl_type;

	sei_ctrl_type q;
	sei_ctrl_type d;
	logic [7:0] mem [P_MEM_BYTES];
	logic [7:0] page_buf [P_PAGE_BYTES];
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic buf_we;
	logic mem_we;
	logic [7:0] mem_rd;
	logic [AW-1:0] mem_idx;
	logic dev_match;

	// ---------------------------------------------------------------
	// Bus events, taken from the settled sampled lines only
	// ---------------------------------------------------------------
	assign rise = q.scl_s & ~q.scl_p;
	assign fall = ~q.scl_s & q.scl_p;
	assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s; // R1 R3
	assign stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s; // R2 R3
	assign mem_rd = mem[q.addr];
	assign mem_idx = {q.page_base, q.prog_cnt[PW-1:0]};
	// Busy device answers nobody, poll sees no acknowledge
	assign dev_match = (q.shift[7:4] == DEV_CODE) && !q.busy; // R4 R11

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		buf_we = 1'b0;
		mem_we = 1'b0;
		// Two flops on every pin before any logic looks at it
		d.scl_m = i_scl;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = i_sda;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		d.rst_m = i_supervisor_reset;
		d.rst_s = q.rst_m;
		d.sda_out = 1'b0;

		// Drain the page one byte a cycle, then wait out the cycle
		if (q.busy) begin
			if (q.prog_cnt < PAGE_END)
				mem_we = q.fill[q.prog_cnt[PW-1:0]]; // R12
			d.prog_cnt = q.prog_cnt + 1'b1;
			if (q.prog_cnt == PROG_LAST) begin
				d.busy = 1'b0; // R22
				d.fill = '0;
			end
		end

		if (q.rst_s) begin
			// Abort the transfer; a running program cycle is left alone
			d.phase = PH_IDLE; // R21
			d.sda_oe = 1'b0;
			d.pending = 1'b0;
			if (!q.busy)
				d.fill = '0;
		end else if (start) begin
			d.phase = PH_DEV; // R1
			d.bit_cnt = BIT_FIRST;
			d.sda_oe = 1'b0;
			// A restart abandons an unfinished page
			if (q.pending) begin
				d.pending = 1'b0;
				d.fill = '0;
			end
		end else if (stop) begin
			d.phase = PH_IDLE; // R2
			d.sda_oe = 1'b0;
			if (q.pending) begin
				d.pending = 1'b0;
				d.busy = 1'b1; // R10
				d.prog_cnt = '0;
			end
		end else if (q.phase != PH_IDLE && q.phase != PH_WAIT) begin
			if (rise) begin
				if (q.bit_cnt < BIT_ACK) begin
					if (q.phase != PH_TX)
						d.shift = {q.shift[6:0], q.sda_s};
					d.bit_cnt = q.bit_cnt + 1'b1;
				end else if (q.bit_cnt == BIT_DONE) begin
					d.master_ack = ~q.sda_s; // R8
				end
			end else if (fall) begin
				if (q.bit_cnt == BIT_ACK) begin
					d.bit_cnt = BIT_DONE;
					unique case (q.phase)
						PH_DEV: begin
							if (dev_match) begin
								d.sda_oe = 1'b1; // R6
								d.rw = q.shift[0]; // R5
								d.byte_idx = IDX_ADDR_HI;
							end else begin
								d.phase = PH_WAIT; // R6
							end
						end
						PH_RX: begin
							d.sda_oe = 1'b1; // R7
							unique case (q.byte_idx)
								IDX_ADDR_HI: begin
									// Upper bits beyond the array are dropped
									d.addr[AW-1:8] = q.shift[AW-9:0]; // R23
									d.byte_idx = IDX_ADDR_LO;
								end
								IDX_ADDR_LO: begin
									d.addr[7:0] = q.shift; // R23
									d.byte_idx = IDX_DATA;
								end
								default: begin
									buf_we = 1'b1; // R12 R14
									d.fill[q.addr[PW-1:0]] = 1'b1;
									d.addr[PW-1:0] = q.addr[PW-1:0] + 1'b1; // R13 R14 R15
									d.page_base = q.addr[AW-1:PW];
									d.pending = 1'b1;
								end
							endcase
						end
						default: begin
							d.sda_oe = 1'b0; // R8
						end
					endcase
				end else if (q.bit_cnt == BIT_DONE) begin
					d.bit_cnt = BIT_FIRST;
					d.sda_oe = 1'b0;
					if ((q.phase == PH_DEV && q.rw) || (q.phase == PH_TX && q.master_ack)) begin
						// Load the next byte; whole counter steps and wraps
						d.phase = PH_TX;
						d.shift = mem_rd;
						d.addr = q.addr + 1'b1; // R15 R16 R19
						d.sda_oe = ~mem_rd[7];
					end else if (q.phase == PH_TX) begin
						d.phase = PH_WAIT; // R8
					end else begin
						d.phase = PH_RX;
					end
				end else if (q.phase == PH_TX && q.bit_cnt != BIT_FIRST) begin
					// Next bit goes out only after the clock falls
					d.shift = {q.shift[6:0], 1'b0}; // R3
					d.sda_oe = ~q.shift[6];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Array and page buffer carry no reset; contents are data
	always_ff @(posedge i_clock) begin
		if (mem_we)
			mem[mem_idx] <= page_buf[q.prog_cnt[PW-1:0]];
		if (buf_we)
			page_buf[q.addr[PW-1:0]] <= q.shift;
	end

	assign o_sda_out = q.sda_out;
	assign o_sda_oe = q.sda_oe;
	assign o_busy = q.busy;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	a_start_enters: assert property (start && !q.rst_s |=> q.phase == PH_DEV && q.bit_cnt == BIT_FIRST) // R1
		else $error("start not taken");
	a_stop_idles: assert property (stop && !q.rst_s |=> q.phase == PH_IDLE && !q.sda_oe) // R2
		else $error("stop not taken");
	a_drive_low_clk: assert property ($rose(q.sda_oe) |-> !q.scl_s) // R3
		else $error("data driven while clock high");
	a_addr_nomatch: assert property ( // R4
		!q.rst_s && !start && !stop && fall && q.phase == PH_DEV && q.bit_cnt == BIT_ACK
		&& q.shift[7:4] != DEV_CODE |=> !q.sda_oe && q.phase == PH_WAIT)
		else $error("foreign address acknowledged");
	a_dir_flag: assert property ( // R5
		!q.rst_s && !start && !stop && fall && q.phase == PH_DEV && q.bit_cnt == BIT_ACK
		&& dev_match |=> q.sda_oe && q.rw == $past(q.shift[0]))
		else $error("direction flag lost");
	a_write_ack: assert property ( // R7
		!q.rst_s && !start && !stop && fall && q.phase == PH_RX && q.bit_cnt == BIT_ACK
		|=> q.sda_oe)
		else $error("write byte not acknowledged");
	a_read_release: assert property ( // R8
		!q.rst_s && !start && !stop && fall && q.phase == PH_TX && q.bit_cnt == BIT_ACK
		|=> !q.sda_oe)
		else $error("data line held in ack slot");
	a_prog_start: assert property ( // R10
		!q.rst_s && !start && stop && q.pending
		|=> q.busy && q.prog_cnt == '0)
		else $error("program cycle not started");
	a_poll_nack: assert property (q.busy && q.phase == PH_DEV |-> ##1 !$rose(q.sda_oe)) // R11
		else $error("acknowledge while programming");
	a_page_keep: assert property (buf_we |=> q.addr[AW-1:PW] == $past(q.addr[AW-1:PW])) // R13
		else $error("page bits moved");
	a_seq_step: assert property ( // R19
		fall && q.phase == PH_TX && q.bit_cnt == BIT_DONE && q.master_ack
		&& !q.rst_s && !start && !stop |=> q.addr == AW'($past(q.addr) + 1'b1))
		else $error("read counter not stepped");
	a_prog_bound: assert property (q.busy |-> q.prog_cnt <= PROG_LAST) // R22
		else $error("program cycle overran");
	a_reset_abort: assert property (q.rst_s |=> q.phase == PH_IDLE && !q.sda_oe && !q.pending) // R21
		else $error("transfer survived supervisor reset");

	// Programming owns the array: no answer on the bus, none started under reset
	a_busy_quiet: assert property (q.busy |-> !$rose(q.sda_oe)) // R10
		else $error("data line pulled while programming");
	a_sup_no_prog: assert property (q.rst_s && !q.busy |=> !q.busy) // R21
		else $error("programming started under supervisor reset");
	// Page loading marks the byte and arms the program cycle
	a_fill_mark: assert property (buf_we |=> q.pending && q.fill[$past(q.addr[PW-1:0])]) // R12
		else $error("page byte not marked");
	a_addr_hi: assert property ( // R23
		!q.rst_s && !start && !stop && fall && q.phase == PH_RX && q.bit_cnt == BIT_ACK
		&& q.byte_idx == IDX_ADDR_HI |=> q.addr[AW-1:8] == $past(q.shift[AW-9:0]))
		else $error("upper address bits misplaced");
	// Framing after the ack slot and the counter's end of array
	a_ack_release: assert property ( // R6
		!q.rst_s && !start && !stop && fall && q.phase == PH_RX && q.bit_cnt == BIT_DONE
		|=> !q.sda_oe && q.bit_cnt == BIT_FIRST)
		else $error("write ack held past ninth clock");
	a_nack_wait: assert property ( // R8
		!q.rst_s && !start && !stop && fall && q.phase == PH_TX && q.bit_cnt == BIT_DONE
		&& !q.master_ack |=> q.phase == PH_WAIT && !q.sda_oe)
		else $error("read went on without acknowledge");
	a_addr_wrap: assert property ( // R16
		!q.rst_s && !start && !stop && fall && q.bit_cnt == BIT_DONE && q.addr == '1
		&& ((q.phase == PH_DEV && q.rw) || (q.phase == PH_TX && q.master_ack)) |=> q.addr == '0)
		else $error("address counter did not wrap");

endmodule // sei_slave

/* File: hdl/sei_pkg.sv */
// Constants and types shared by the serial memory bus slave
// What this block does
// R1 - Start is data falling, clock high
// R2 - Stop is data rising, clock high
// R3 - Data moves only while clock low
// R4 - Match upper address nibble against 1010
// R5 - Last address bit: 1 read, 0 write
// R6 - Acknowledge on ninth clock, only when matched
// R7 - Acknowledge every byte once write-addressed
// R8 - Read: send byte, sample ack, continue/stop
// R9 - Master byte write: address, two bytes, data
// R10 - Stop after write starts programming, bus ignored
// R11 - Poll: no acknowledge while programming runs
// R12 - Page write up to 64 bytes, one cycle
// R13 - Page write increments only in-page bits
// R14 - Over 64 bytes wraps, overwriting earlier data
// R15 - Counter holds last address plus one
// R16 - Counter wraps to zero after last byte
// R17 - Random read: dummy write then read start
// R18 - Master ends read with no-ack then stop
// R19 - Sequential read increments whole address counter
// R20 - Master starts on idle bus, ends with stop
// R21 - Supervisor reset aborts bus, programming still completes
// R22 - Programming finishes within 5 ms
// R23 - Address is 13 bits, top three ignored
package sei_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned PROGRAM_CYCLE_TIME_NS = 5000000;
	// Longest time, so the division rounds down
	localparam int unsigned PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Array geometry, addressing and bit counter framing
	// ---------------------------------------------------------------
	localparam int unsigned MEM_BYTES = 8192;
	localparam int unsigned PAGE_BYTES = 64;
	localparam logic [3:0] DEV_CODE = 4'ha;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_DONE = 4'h9;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [1:0] IDX_ADDR_HI = 2'h0;
	localparam logic [1:0] IDX_ADDR_LO = 2'h1;
	localparam logic [1:0] IDX_DATA = 2'h2;

	// ---------------------------------------------------------------
	// Bus phases
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_DEV = 3'b001,
		PH_RX = 3'b010,
		PH_TX = 3'b011,
		PH_WAIT = 3'b100
	} sei_phase_type;

endpackage

/* File: verif/sei_master.sv */
// Bus master model: drives the serial clock and releases or pulls the data line
`timescale 1ns/1ps
module sei_master (
	input wire logic i_clock,
	input wire logic i_sda,
	output logic o_scl = 1'b1,
	output logic o_sda = 1'b1
);
	// Eighth steps of the 200 ns bus period, moved on the falling system edge
	task automatic q(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	// One bit; data moves mid low half so the slave's sync delay never sees a false edge
	task automatic bit_x(input logic b, output logic r);
		q(2);
		o_sda = b;
		q(2);
		o_scl = 1'b1;
		q(2);
		r = i_sda;
		q(2);
		o_scl = 1'b0;
	endtask
	// Serves as repeated start too, since the line is raised first while the clock is low
	task automatic start();
		q(2);
		o_sda = 1'b1;
		q(2);
		o_scl = 1'b1;
		q(4);
		o_sda = 1'b0;
		q(4);
		o_scl = 1'b0;
	endtask
	// Clock stays high afterwards; the tail gives the bus free time
	task automatic stop();
		q(2);
		o_sda = 1'b0;
		q(2);
		o_scl = 1'b1;
		q(4);
		o_sda = 1'b1;
		q(8);
	endtask
	// Byte out MSB first, then the line is released to sample the answer
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	// A clear ack bit leaves the final byte unanswered before the stop
	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(~ack, r);
	endtask
endmodule // sei_master

/* File: verif/testbench.sv */
// Self-checking bench for the serial memory bus slave
`timescale 1ns/1ps
module testbench;
	import sei_pkg::*;
	localparam logic [7:0] AW = {DEV_CODE, 4'h0};
	localparam logic [7:0] AR = {DEV_CODE, 4'h1};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sup = 1'b0;
	logic scl, sda_m, sda_oe, sda_out, busy, ack;
	logic [7:0] got [0:63];
	int mismatches = 0;
	int num_checks = 0;
	// Open-drain data wire with pull-up
	wire logic sda = sda_oe ? (sda_out & sda_m) : sda_m;
	always #12.5 clk = ~clk;
	// Short programming time keeps the run brief
	sei_slave #(.P_PROG_CYCLES(100)) dut_u (.i_clock(clk), .i_reset_n(rst_n), .i_scl(scl),
		.i_sda(sda), .i_supervisor_reset(sup), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_busy(busy));
	sei_master master_u (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Write address phase: device code and two address bytes
	task automatic set_addr(input logic [15:0] a);
		master_u.start();
		master_u.wr(AW, ack);
		check(8'(ack), 8'h01);
		master_u.wr(a[15:8], ack);
		check(8'(ack), 8'h01);
		master_u.wr(a[7:0], ack);
		check(8'(ack), 8'h01);
	endtask
	// Bounded wait for programming to finish
	task automatic wait_prog();
		for (int n = 0; n < 110 && busy !== 1'b0; n++) @(negedge clk);
		check(8'(busy), 8'h00);
	endtask
	// Random or current-address read of n bytes, last one unanswered
	task automatic rd_seq(input bit rnd, input logic [15:0] a, input int n);
		if (rnd) set_addr(a);
		master_u.start();
		master_u.wr(AR, ack);
		check(8'(ack), 8'h01);
		for (int i = 0; i < n; i++) master_u.rd(i < n - 1, got[i]);
		master_u.stop();
	endtask
	// Bits before any start, then a foreign device code
	task automatic t_foreign();
		master_u.wr(AW, ack);
		check(8'(ack), 8'h00);
		master_u.stop();
		master_u.start();
		master_u.wr(8'h90, ack);
		check(8'(ack), 8'h00);
		master_u.stop();
		check(8'(busy), 8'h00);
	endtask
	// Byte write to the top cell with junk upper bits, then polling
	task automatic t_byte();
		set_addr(16'hffff);
		master_u.wr(8'h5a, ack);
		check(8'(ack), 8'h01);
		master_u.stop();
		check(8'(busy), 8'h01);
		master_u.start();
		master_u.wr(AW, ack);
		check(8'(ack), 8'h00);
		master_u.stop();
		wait_prog();
		master_u.start();
		master_u.wr(AW, ack);
		check(8'(ack), 8'h01);
		master_u.stop();
	endtask
	// 66 bytes from offset 62: in-page wrap overwrites the first two
	task automatic t_page();
		set_addr(16'h003e);
		for (int k = 0; k < 66; k++) begin
			master_u.wr(k[7:0], ack);
			check(8'(ack), 8'h01);
		end
		master_u.stop();
		wait_prog();
		rd_seq(1, 16'h0000, 64);
		for (int o = 0; o < 64; o++) check(got[o], 8'(o + 2));
	endtask
	// Read across the array end, then a current-address read
	task automatic t_wrap();
		rd_seq(1, 16'h1fff, 3);
		check(got[0], 8'h5a);
		check(got[1], 8'h02);
		check(got[2], 8'h03);
		rd_seq(0, 16'h0000, 1);
		check(got[0], 8'h04);
	endtask
	// Supervisor reset: running cycle completes, new access and programming refused
	task automatic t_sup();
		set_addr(16'h0011);
		master_u.wr(8'hc3, ack);
		master_u.stop();
		sup = 1'b1;
		repeat (10) @(negedge clk);
		check(8'(busy), 8'h01);
		wait_prog();
		master_u.start();
		master_u.wr(AW, ack);
		check(8'(ack), 8'h00);
		master_u.stop();
		sup = 1'b0;
		set_addr(16'h0010);
		master_u.wr(8'h77, ack);
		sup = 1'b1;
		master_u.stop();
		check(8'(busy), 8'h00);
		sup = 1'b0;
		rd_seq(1, 16'h0010, 2);
		check(got[0], 8'h12);
		check(got[1], 8'hc3);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_foreign();
		t_byte();
		t_page();
		t_wrap();
		t_sup();
		give_verdict();
	end
	// Watchdog, about three times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
endmodule // testbench
